// ==== bench/stkz_check_model.sv ====
module stkz_check_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic check_go,
    input wire logic [3:0] check_sel,
    input wire logic [3:0] fail_sel,
    input wire logic slow,
    output logic check_done,
    output logic check_pass
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend;
    logic [1:0] cnt;
    // check engine: answers each launch promptly or after three idle cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            cnt <= 2'h0;
            check_done <= 1'b0;
            check_pass <= 1'b0;
        end else begin
            check_done <= 1'b0;
            check_pass <= ~check_pass; // result is noise outside the done cycle
            if (check_go) begin
                pend <= 1'b1;
                cnt <= slow ? 2'h3 : 2'h0;
            end else if (pend && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (pend) begin
                pend <= 1'b0;
                check_done <= 1'b1;
                check_pass <= (check_sel != fail_sel);
            end
        end
    end
endmodule

// ==== bench/stkz_ctrl_asserts.sv ====
module stkz_ctrl_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_event,
    input wire logic key_rd,
    input wire logic [stkz_pkg::KEY_W-1:0] key_rd_data,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_accepted,
    input wire logic [stkz_pkg::CHECK_W-1:0] check_sel,
    input wire logic check_go,
    input wire logic check_done,
    input wire logic engine_ready,
    input wire logic busy,
    input wire logic locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic outstanding;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a check is open from its launch until its answer or a restart; stale answers during a wipe are ignored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outstanding <= 1'b0;
        end else if (check_done || reset_event) begin
            outstanding <= 1'b0;
        end else if (check_go) begin
            outstanding <= 1'b1;
        end
    end
    // a check finishing, split by whether more follow
    sequence s_mid_done;
        outstanding && check_done && check_sel != stkz_pkg::CHK_LAST && !reset_event;
    endsequence
    sequence s_last_done;
        outstanding && check_done && check_sel == stkz_pkg::CHK_LAST && !reset_event;
    endsequence
    AST_NEXT_CHECK: assert property (
        s_mid_done |=> check_go && check_sel == $past(check_sel) + 4'h1) else $error("next check not launched");
    AST_SEQ_END: assert property (
        s_last_done ##1 !reset_event |-> ##1 (engine_ready != locked)) else $error("no single outcome after last check");
    AST_GO_PULSE: assert property (
        check_go |=> !check_go) else $error("check launch longer than one cycle");
    AST_EVENT_RESTART: assert property (
        reset_event |-> ##[1:2] (busy && !engine_ready)) else $error("reset event did not restart tests");
    // state outputs may lag one cycle behind the event
    AST_LOCK_HOLD: assert property (
        locked && !reset_event && !$past(reset_event) |=> locked) else $error("lock left without reset");
    AST_LOCKED_REFUSE: assert property (
        locked && $past(locked) |-> !req_ready) else $error("request ready while locked");
    AST_REQ_ACCEPT: assert property (
        req_valid && req_ready |=> req_accepted) else $error("ready request not accepted");
    AST_RD_ZERO: assert property (
        key_rd |=> key_rd_data == 32'h0) else $error("key read returned nonzero");
endmodule

bind stkz_ctrl stkz_ctrl_chk u_chk (.clk_sys, .rst, .reset_event, .key_rd, .key_rd_data, .req_valid, .req_ready,
    .req_accepted, .check_sel, .check_go, .check_done, .engine_ready, .busy, .locked);

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, reset_event, key_wr, key_rd, req_valid, check_done, check_pass, slow;
    logic [stkz_pkg::SLOT_AW-1:0] key_slot, use_slot;
    logic [stkz_pkg::KEY_W-1:0] key_data, key_rd_data, use_key;
    logic [3:0] check_sel, fail_sel;
    logic check_go, req_ready, engine_ready, busy, locked, req_accepted;
    logic [15:0] seen;
    logic seen_clr;
    int n_mismatch = 0;
    int tests_run = 0;
    stkz_ctrl dut (.clk_sys, .rst, .reset_event, .key_wr, .key_slot, .key_data, .key_rd, .key_rd_data, .use_slot,
        .use_key, .req_valid, .req_ready, .check_sel, .check_go, .check_done, .check_pass, .engine_ready, .busy,
        .locked, .req_accepted);
    stkz_check_model u_model (.clk_sys, .rst, .check_go, .check_sel, .fail_sel, .slow, .check_done, .check_pass);
    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // note every check that gets launched; one process owns the record, cleared on request
    always @(posedge clk_sys) begin
        if (seen_clr) begin
            seen <= 16'h0;
        end else if (check_go === 1'b1) begin
            seen[check_sel] <= 1'b1;
        end
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for a pass or fail outcome
    task wait_outcome;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 300 && engine_ready !== 1'b1 && locked !== 1'b1; i++) @(posedge clk_sys);
        // a limit that runs out shows up here as a mismatch
        chk("single outcome", 32'h1, {31'h0, engine_ready ^ locked});
    endtask
    task run_tests(input logic [3:0] f, input logic s);
        seen_clr <= 1'b1;
        fail_sel <= f;
        slow <= s;
        reset_event <= 1'b1;
        @(posedge clk_sys);
        reset_event <= 1'b0;
        seen_clr <= 1'b0;
        @(posedge clk_sys);
        chk("busy", 32'h1, {31'h0, busy});
        chk("req_ready", 32'h0, {31'h0, req_ready});
        wait_outcome();
    endtask
    task put_key(input logic [2:0] s, input logic [31:0] d);
        key_wr <= 1'b1;
        key_slot <= s;
        key_data <= d;
        key_rd <= 1'b1;
        use_slot <= s;
        @(posedge clk_sys) key_wr <= 1'b0;
        key_rd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("cleared slot", 32'h0, use_key);
        @(posedge clk_sys);
        chk("key_rd_data", 32'h0, key_rd_data);
        chk("use_key", d, use_key);
    endtask
    task t_powerup;
        wait_outcome();
        chk("checks run", 32'h1FF, {16'h0, seen});
        chk("engine_ready", 32'h1, {31'h0, engine_ready});
        chk("busy", 32'h0, {31'h0, busy});
    endtask
    task t_keys;
        put_key(3'h3, 32'hAAAA5555);
        put_key(3'h3, 32'h12345678);
        run_tests(4'hF, 1'b0);
        chk("wiped key", 32'h0, use_key);
    endtask
    task t_request;
        chk("req_ready", 32'h1, {31'h0, req_ready});
        req_valid <= 1'b1;
        @(posedge clk_sys) req_valid <= 1'b0;
        @(posedge clk_sys);
        chk("req_accepted", 32'h1, {31'h0, req_accepted});
    endtask
    task t_fail;
        run_tests(4'h4, 1'b1);
        chk("locked", 32'h1, {31'h0, locked});
        chk("checks run", 32'h1FF, {16'h0, seen});
        req_valid <= 1'b1;
        key_wr <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("req_accepted", 32'h0, {31'h0, req_accepted});
        chk("req_ready", 32'h0, {31'h0, req_ready});
        chk("locked key", 32'h0, use_key);
        req_valid <= 1'b0;
        key_wr <= 1'b0;
        run_tests(4'h8, 1'b0);
        chk("locked again", 32'h1, {31'h0, locked});
        run_tests(4'hF, 1'b0);
        chk("engine_ready", 32'h1, {31'h0, engine_ready});
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        {reset_event, key_wr, key_rd, req_valid, slow} = 5'h0;
        key_slot = 3'h0;
        use_slot = 3'h0;
        key_data = 32'h0;
        fail_sel = 4'hF;
        seen_clr = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        seen_clr <= 1'b0;
        t_powerup();
        t_keys();
        t_request();
        t_fail();
        stop_test();
    end
    // watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end
endmodule

// ==== include/stkz_pkg.sv ====
package stkz_pkg;
    // key store geometry
    localparam int KEY_SLOTS = 8;
    localparam int SLOT_AW = 3;
    localparam int KEY_W = 32;
    localparam logic [SLOT_AW-1:0] SLOT_FIRST = 3'h0;
    localparam logic [SLOT_AW-1:0] SLOT_LAST = 3'h7;
    localparam logic [KEY_W-1:0] KEY_ZERO = 32'h0;
    // known answer check list
    localparam int CHECK_COUNT = 9;
    localparam int CHECK_W = 4;
    localparam logic [CHECK_W-1:0] CHK_AES_CCM_ENC = 4'h0;
    localparam logic [CHECK_W-1:0] CHK_AES_CCM_DEC = 4'h1;
    localparam logic [CHECK_W-1:0] CHK_AES_ECB_ENC = 4'h2;
    localparam logic [CHECK_W-1:0] CHK_AES_ECB_DEC = 4'h3;
    localparam logic [CHECK_W-1:0] CHK_TDES_ENC = 4'h4;
    localparam logic [CHECK_W-1:0] CHK_TDES_DEC = 4'h5;
    localparam logic [CHECK_W-1:0] CHK_HMAC_SHA1 = 4'h6;
    localparam logic [CHECK_W-1:0] CHK_HMAC_SHA256 = 4'h7;
    localparam logic [CHECK_W-1:0] CHK_AES_CMAC = 4'h8;
    localparam logic [CHECK_W-1:0] CHK_LAST = 4'h8;
    // controller states, one-hot
    typedef enum logic [4:0] {
        ST_ZERO = 5'h01,
        ST_LAUNCH = 5'h02,
        ST_WAIT = 5'h04,
        ST_READY = 5'h08,
        ST_LOCKED = 5'h10
    } stkz_state_e;
endpackage

// ==== src/stkz_check_seq.sv ====
module stkz_check_seq (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    output logic [stkz_pkg::CHECK_W-1:0] check_sel,
    output logic check_go,
    input wire logic check_done,
    input wire logic check_pass,
    output logic seq_done,
    output logic seq_pass
);
    logic running;
    logic waiting;
    logic any_fail;

    // walks all nine checks in a fixed order; a failure does not cut it short
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
            waiting <= 1'b0;
            any_fail <= 1'b0;
            check_sel <= stkz_pkg::CHK_AES_CCM_ENC;
            check_go <= 1'b0;
            seq_done <= 1'b0;
            seq_pass <= 1'b0;
        end else begin
            check_go <= 1'b0;
            seq_done <= 1'b0;
            if (start) begin
                running <= 1'b1;
                waiting <= 1'b1;
                any_fail <= 1'b0;
                check_sel <= stkz_pkg::CHK_AES_CCM_ENC;
                check_go <= 1'b1;
                seq_pass <= 1'b0;
            end else if (running && waiting && check_done) begin
                if (check_sel == stkz_pkg::CHK_LAST) begin
                    running <= 1'b0;
                    waiting <= 1'b0;
                    seq_done <= 1'b1;
                    seq_pass <= !any_fail && check_pass;
                end else begin
                    check_sel <= check_sel + 4'h1;
                    check_go <= 1'b1;
                end
                any_fail <= any_fail | !check_pass;
            end
        end
    end
endmodule

// ==== src/stkz_ctrl.sv ====
// Notes on behaviour
// R01 - self-test starts by itself out of reset, no request needed
// R02 - all checks run as one sequence with one pass or fail outcome
// R03 - a failed check locks the engine, all crypto requests refused
// R04 - a module reset event restarts the whole sequence at once
// R05 - engine released for requests only after every check passed
// R06 - while locked every input but reset is ignored
// R07 - repeated failure stays locked, no degraded mode exists
// R08 - reset clears every key slot; a new key clears its slot first
// R09 - keys only come from outside writes, none generated here
// R10 - checks cover AES CCM/ECB, 3DES ECB, HMAC SHA-1/256, AES-CMAC
// R11 - external key reads return zeros
// R12 - not ready and no requests accepted while testing
module stkz_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_event,
    input wire logic key_wr,
    input wire logic [stkz_pkg::SLOT_AW-1:0] key_slot,
    input wire logic [stkz_pkg::KEY_W-1:0] key_data,
    input wire logic key_rd,
    output logic [stkz_pkg::KEY_W-1:0] key_rd_data,
    input wire logic [stkz_pkg::SLOT_AW-1:0] use_slot,
    output logic [stkz_pkg::KEY_W-1:0] use_key,
    input wire logic req_valid,
    output logic req_ready,
    output logic [stkz_pkg::CHECK_W-1:0] check_sel,
    output logic check_go,
    input wire logic check_done,
    input wire logic check_pass,
    output logic engine_ready,
    output logic busy,
    output logic locked,
    output logic req_accepted
);
    stkz_pkg::stkz_state_e state;
    stkz_pkg::stkz_state_e next_state;
    logic [stkz_pkg::SLOT_AW-1:0] zero_slot;
    logic wipe_pending;
    logic [stkz_pkg::SLOT_AW-1:0] wipe_slot;
    logic [stkz_pkg::KEY_W-1:0] wipe_key;
    logic mem_wr;
    logic [stkz_pkg::SLOT_AW-1:0] mem_slot;
    logic [stkz_pkg::KEY_W-1:0] mem_data;
    logic seq_start;
    logic seq_done;
    logic seq_pass;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            // R08 clear all slots
            stkz_pkg::ST_ZERO: begin
                if (zero_slot == stkz_pkg::SLOT_LAST) begin
                    next_state = stkz_pkg::ST_LAUNCH;
                end
            end
            // R01 auto launch
            stkz_pkg::ST_LAUNCH: begin
                next_state = stkz_pkg::ST_WAIT;
            end
            // R02 single outcome
            stkz_pkg::ST_WAIT: begin
                if (seq_done) begin
                    next_state = seq_pass ? stkz_pkg::ST_READY : stkz_pkg::ST_LOCKED;
                end
            end
            stkz_pkg::ST_READY: begin
                next_state = stkz_pkg::ST_READY;
            end
            // R06 R07 only reset leaves
            stkz_pkg::ST_LOCKED: begin
                next_state = stkz_pkg::ST_LOCKED;
            end
            default: begin
                next_state = stkz_pkg::ST_ZERO;
            end
        endcase
        // R04 reset event restarts everything
        if (reset_event) begin
            next_state = stkz_pkg::ST_ZERO;
        end
    end

    // state register; power-up lands in the wipe first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= stkz_pkg::ST_ZERO;
        end else begin
            state <= next_state;
        end
    end

    // wipe slot counter, restarted by a reset event
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_slot <= stkz_pkg::SLOT_FIRST;
        end else if (reset_event) begin
            zero_slot <= stkz_pkg::SLOT_FIRST;
        end else if (state == stkz_pkg::ST_ZERO) begin
            zero_slot <= zero_slot + 3'h1;
        end
    end

    // R08 overwrite clears the slot, then writes the new key a cycle later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wipe_pending <= 1'b0;
            wipe_slot <= stkz_pkg::SLOT_FIRST;
            wipe_key <= stkz_pkg::KEY_ZERO;
        end else if (reset_event || state != stkz_pkg::ST_READY) begin
            wipe_pending <= 1'b0;
        end else if (key_wr && !wipe_pending) begin
            wipe_pending <= 1'b1;
            wipe_slot <= key_slot;
            wipe_key <= key_data;
        end else begin
            wipe_pending <= 1'b0;
        end
    end

    // memory write mux in priority order: bulk wipe, key load, then slot clear
    // R09 keys only come in through key_wr; no key source inside
    always_comb begin
        mem_wr = 1'b0;
        mem_slot = zero_slot;
        mem_data = stkz_pkg::KEY_ZERO;
        if (state == stkz_pkg::ST_ZERO) begin
            mem_wr = 1'b1;
        end else if (wipe_pending) begin
            mem_wr = 1'b1;
            mem_slot = wipe_slot;
            mem_data = wipe_key;
        end else if (key_wr && state == stkz_pkg::ST_READY && !reset_event) begin
            mem_wr = 1'b1;
            mem_slot = key_slot;
        end
    end

    stkz_key_store u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(mem_wr),
        .wr_slot(mem_slot),
        .wr_key(mem_data),
        .rd_slot(use_slot),
        .rd_key(use_key)
    );

    assign seq_start = (state == stkz_pkg::ST_LAUNCH);

    // R10 nine checks in order
    stkz_check_seq u_seq (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(seq_start),
        .check_sel(check_sel),
        .check_go(check_go),
        .check_done(check_done && state == stkz_pkg::ST_WAIT),
        .check_pass(check_pass),
        .seq_done(seq_done),
        .seq_pass(seq_pass)
    );

    // R11 key read port never shows a key
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            key_rd_data <= stkz_pkg::KEY_ZERO;
        end else if (key_rd) begin
            key_rd_data <= stkz_pkg::KEY_ZERO;
        end
    end

    // R03 R05 R12 requests only taken once released
    assign req_ready = (state == stkz_pkg::ST_READY) && !reset_event;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_accepted <= 1'b0;
        end else begin
            req_accepted <= req_valid && req_ready;
        end
    end

    // status levels
    // R12 busy while wiping or testing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            engine_ready <= 1'b0;
            busy <= 1'b1;
            locked <= 1'b0;
        end else begin
            engine_ready <= next_state == stkz_pkg::ST_READY;
            busy <= next_state == stkz_pkg::ST_ZERO || next_state == stkz_pkg::ST_LAUNCH
                || next_state == stkz_pkg::ST_WAIT;
            locked <= next_state == stkz_pkg::ST_LOCKED;
        end
    end
endmodule

// ==== src/stkz_key_store.sv ====
module stkz_key_store (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [stkz_pkg::SLOT_AW-1:0] wr_slot,
    input wire logic [stkz_pkg::KEY_W-1:0] wr_key,
    input wire logic [stkz_pkg::SLOT_AW-1:0] rd_slot,
    output logic [stkz_pkg::KEY_W-1:0] rd_key
);
    logic [stkz_pkg::KEY_W-1:0] mem [stkz_pkg::KEY_SLOTS];

    // write port; zeroize is a write of zeros driven by the controller
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_key;
        end
    end

    // registered internal read, feeds the datapath only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_key <= stkz_pkg::KEY_ZERO;
        end else begin
            rd_key <= mem[rd_slot];
        end
    end
endmodule
